// >>> design/gplc_map.svh
// register offsets, field positions, reset values and timing counts
// Functional notes
// - set led_select bit turns shared pin into LED output; pin 0 is bit 28, reset zero.
// - polarity one: high pin level sets that pin's interrupt status bit.
// - polarity zero: low pin level sets that pin's interrupt status bit.
// - pin interrupt reaches host interrupt only when its enable bit is set.
// - active level must last over 40 ns before counting as interrupt source; a level seen at a single 50 ns clock sample already counts.
// - three-bit select picks config memory pin functions; 010 and 100 reserved.
// - drive type bit set is push/pull, clear is open-drain; pin 0 bit 16.
// - direction bit set makes pin output, clear makes input; pin 0 bit 8.
// - output-only bits 3 and 4 drive output pins 3 and 4.
// - output pin drives last written data bit; pin 0 is bit 0.
// - reading data bits 2:0 returns sampled pin levels, not stored values.
`ifndef GPLC_MAP_SVH
`define GPLC_MAP_SVH
`define GPLC_CFG_OFFSET     12'h088
`define GPLC_IRQ_STS_OFFSET 12'h0a0
`define GPLC_IRQ_EN_OFFSET  12'h0a4
`define GPLC_LED_LSB        28
`define GPLC_POL_LSB        24
`define GPLC_FUNC_LSB       20
`define GPLC_BUF_LSB        16
`define GPLC_DIR_LSB        8
`define GPLC_GPO_LSB        3
`define GPLC_DATA_LSB       0
`define GPLC_CFG_WMASK      32'h7777071f
`define GPLC_CFG_RESET      32'h00000000
`define GPLC_MIN_PULSE_NS   40
`define GPLC_CLK_PERIOD_NS  50
`endif

// >>> design/gplc_pkg.sv
// types for the pin configuration block
package gplc_pkg;
    typedef enum logic [2:0] {
        GPLC_FN_MEM     = 3'h0,
        GPLC_FN_GPO_GPO = 3'h1,
        GPLC_FN_RSV2    = 3'h2,
        GPLC_FN_GPO_RXV = 3'h3,
        GPLC_FN_RSV4    = 3'h4,
        GPLC_FN_TXE_GPO = 3'h5,
        GPLC_FN_TXE_RXV = 3'h6,
        GPLC_FN_CLKS    = 3'h7
    } gplc_func_t;
    typedef enum logic [1:0] {GPLC_APB_IDLE, GPLC_APB_ACCESS} gplc_apb_t;
endpackage

// >>> design/gplc_level_filter.sv
// qualifies an input level that must persist before it counts
`include "gplc_map.svh"
module gplc_level_filter #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] levelIn,
    output logic      [WIDTH-1:0] qualified
);
    // samples needed: minimum pulse over clock period plus one, which is one sample at 40 ns and 50 ns
    localparam int HOLD = `GPLC_MIN_PULSE_NS / `GPLC_CLK_PERIOD_NS + 1;
    localparam int CW   = (HOLD > 1) ? $clog2(HOLD) : 1;
    logic [CW-1:0] runCnt_reg [WIDTH];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            qualified <= '0;
            for (int i = 0; i < WIDTH; i++) begin
                runCnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (!levelIn[i]) begin
                    runCnt_reg[i] <= '0;
                end else if (runCnt_reg[i] != CW'(HOLD - 1)) begin
                    runCnt_reg[i] <= runCnt_reg[i] + 1'b1;
                end
                qualified[i] <= levelIn[i] && (runCnt_reg[i] == CW'(HOLD - 1));
            end
        end
    end
endmodule

// >>> design/gplc_pin_config.sv
// pin configuration register, pin muxing and pin interrupts over APB
//
// Implementation choice: the APB slave port.
`include "gplc_map.svh"
module gplc_pin_config (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  gpioIn,
    output logic      [2:0]  gpioOut,
    output logic      [2:0]  gpioOe,
    input  wire logic [2:0]  ledState,
    input  wire logic        cfgmemDataOut,
    input  wire logic        cfgmemDataOe,
    input  wire logic        cfgmemClkOut,
    output logic             cfgmemDataIn,
    input  wire logic        txEn,
    input  wire logic        txClk,
    input  wire logic        rxDv,
    input  wire logic        rxClk,
    input  wire logic        cfgmemPinIn,
    output logic             cfgmemDataPinOut,
    output logic             cfgmemDataPinOe,
    output logic             cfgmemClockPinOut,
    output logic             irq
);
    logic [31:0] cfg_reg;
    logic [2:0]  irqStatus_reg;
    logic [2:0]  irqEnable_reg;
    logic [2:0]  sample_reg;
    logic [2:0]  qualLevel;
    logic [2:0]  rawActive;
    logic        wrEn;
    logic        rdEn;
    logic        cfgHit;
    logic        stsHit;
    logic        enHit;
    logic [31:0] cfgWrite;
    logic [2:0]  ledSel;
    logic [2:0]  pol;
    logic [2:0]  bufType;
    logic [2:0]  dir;
    logic [1:0]  gpoVal;
    logic [2:0]  dataVal;
    gplc_pkg::gplc_func_t func;

    function automatic logic [2:0] field3(input logic [31:0] r, input int lsb);
        field3 = r[lsb +: 3];
    endfunction

    assign ledSel  = field3(cfg_reg, `GPLC_LED_LSB);
    assign pol     = field3(cfg_reg, `GPLC_POL_LSB);
    assign func    = gplc_pkg::gplc_func_t'(field3(cfg_reg, `GPLC_FUNC_LSB));
    assign bufType = field3(cfg_reg, `GPLC_BUF_LSB);
    assign dir     = field3(cfg_reg, `GPLC_DIR_LSB);
    assign gpoVal  = cfg_reg[`GPLC_GPO_LSB +: 2];
    assign dataVal = field3(cfg_reg, `GPLC_DATA_LSB);

    // apb: one wait-free access phase
    assign wrEn   = psel && penable && pwrite;
    assign rdEn   = psel && penable && !pwrite;
    assign cfgHit = (paddr == `GPLC_CFG_OFFSET);
    assign stsHit = (paddr == `GPLC_IRQ_STS_OFFSET);
    assign enHit  = (paddr == `GPLC_IRQ_EN_OFFSET);
    assign cfgWrite = pwdata & `GPLC_CFG_WMASK;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(cfgHit || stsHit || enHit);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_reg <= `GPLC_CFG_RESET;
        end else if (wrEn && pready && cfgHit) begin
            cfg_reg <= cfgWrite;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqEnable_reg <= 3'h0;
        end else if (wrEn && pready && enHit) begin
            irqEnable_reg <= pwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // idle level of pulled-up pins, so no false low event after reset
            sample_reg <= 3'h7;
        end else begin
            sample_reg <= gpioIn;
        end
    end

    gplc_level_filter #(.WIDTH(3)) u_filter (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .levelIn   (rawActive),
        .qualified (qualLevel)
    );

    assign rawActive = ~(sample_reg ^ pol);

    // status set wins over read clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStatus_reg <= 3'h0;
        end else if (rdEn && pready && stsHit) begin
            // clear only what the read reported
            irqStatus_reg <= (irqStatus_reg & ~prdata[2:0]) | qualLevel;
        end else begin
            irqStatus_reg <= irqStatus_reg | qualLevel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_reg & irqEnable_reg);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            if (pwrite) begin
                prdata <= 32'h0;
            end else if (cfgHit) begin
                prdata <= {cfg_reg[31:3], sample_reg} & `GPLC_CFG_WMASK;
            end else if (stsHit) begin
                prdata <= {29'h0, irqStatus_reg};
            end else if (enHit) begin
                prdata <= {29'h0, irqEnable_reg};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // shared pins: led duty, else gpio with direction and drive type
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpioOut <= 3'h0;
            gpioOe  <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ledSel[i]) begin
                    gpioOut[i] <= ledState[i];
                    gpioOe[i]  <= 1'b1;
                end else if (!dir[i]) begin
                    gpioOut[i] <= 1'b0;
                    gpioOe[i]  <= 1'b0;
                end else if (bufType[i]) begin
                    gpioOut[i] <= dataVal[i];
                    gpioOe[i]  <= 1'b1;
                end else begin
                    gpioOut[i] <= 1'b0;
                    gpioOe[i]  <= !dataVal[i];
                end
            end
        end
    end

    // config memory pin remap; reserved codes release the data pin and drive the clock pin low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfgmemDataPinOut  <= 1'b0;
            cfgmemDataPinOe   <= 1'b0;
            cfgmemClockPinOut <= 1'b0;
            cfgmemDataIn      <= 1'b0;
        end else begin
            cfgmemDataIn <= cfgmemPinIn;
            case (func)
                gplc_pkg::GPLC_FN_MEM: begin
                    cfgmemDataPinOut  <= cfgmemDataOut;
                    cfgmemDataPinOe   <= cfgmemDataOe;
                    cfgmemClockPinOut <= cfgmemClkOut;
                end
                gplc_pkg::GPLC_FN_GPO_GPO: begin
                    cfgmemDataPinOut  <= gpoVal[0];
                    cfgmemDataPinOe   <= 1'b1;
                    cfgmemClockPinOut <= gpoVal[1];
                end
                gplc_pkg::GPLC_FN_GPO_RXV: begin
                    cfgmemDataPinOut  <= gpoVal[0];
                    cfgmemDataPinOe   <= 1'b1;
                    cfgmemClockPinOut <= rxDv;
                end
                gplc_pkg::GPLC_FN_TXE_GPO: begin
                    cfgmemDataPinOut  <= txEn;
                    cfgmemDataPinOe   <= 1'b1;
                    cfgmemClockPinOut <= gpoVal[1];
                end
                gplc_pkg::GPLC_FN_TXE_RXV: begin
                    cfgmemDataPinOut  <= txEn;
                    cfgmemDataPinOe   <= 1'b1;
                    cfgmemClockPinOut <= rxDv;
                end
                gplc_pkg::GPLC_FN_CLKS: begin
                    cfgmemDataPinOut  <= txClk;
                    cfgmemDataPinOe   <= 1'b1;
                    cfgmemClockPinOut <= rxClk;
                end
                default: begin
                    cfgmemDataPinOut  <= 1'b0;
                    cfgmemDataPinOe   <= 1'b0;
                    cfgmemClockPinOut <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> test/gplc_pin_config_asserts.sv
// port checker for the pin configuration block
`include "gplc_map.svh"
module gplc_pin_config_asserts (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  gpioOut,
    input wire logic [2:0]  gpioOe,
    input wire logic        cfgmemDataPinOut,
    input wire logic        cfgmemClockPinOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cfgReg;
    wire         isCfg = paddr == `GPLC_CFG_OFFSET;
    wire         mapped = isCfg || paddr inside {`GPLC_IRQ_STS_OFFSET, `GPLC_IRQ_EN_OFFSET};
    // shadow of the stored config word
    always_ff @(posedge ref_clk) begin
        if (rst) cfgReg <= 32'h0;
        else if (pready && pwrite && isCfg) cfgReg <= pwdata & `GPLC_CFG_WMASK;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence setup(c);
        psel && !penable && c;
    endsequence
    sequence still(c);
        $stable(cfgReg) && c;
    endsequence
    a_refuse_unmapped: assert property (setup(!mapped)
        |=> pready && pslverr && !prdata) else $error("unmapped not refused");
    a_mapped_ok: assert property (setup(mapped)
        |=> pready && !pslverr) else $error("mapped access refused");
    a_rsv_zero: assert property (pready && !pwrite && isCfg
        |-> !(prdata & ~`GPLC_CFG_WMASK)) else $error("reserved bits set");
    a_cfg_readback: assert property (pready && !pwrite && isCfg
        |-> prdata[30:3] == cfgReg[30:3]) else $error("config readback wrong");
    a_input_idle: assert property (still(1'b1)
        |-> !(gpioOe & ~cfgReg[10:8] & ~cfgReg[30:28])) else $error("input pin driven");
    a_push_pull: assert property (still(cfgReg[8] && cfgReg[16] && !cfgReg[28])
        |-> gpioOe[0] && gpioOut[0] == cfgReg[0]) else $error("push-pull pin wrong");
    a_open_drain: assert property (still(cfgReg[8] && !cfgReg[16] && !cfgReg[28])
        |-> gpioOe[0] == !cfgReg[0] && !gpioOut[0]) else $error("open-drain pin wrong");
    a_gpo_route: assert property (still(cfgReg[22:20] == 3'h1)
        |-> {cfgmemClockPinOut, cfgmemDataPinOut} == cfgReg[4:3]) else $error("gpo pins wrong");
endmodule
bind gplc_pin_config gplc_pin_config_asserts u_asserts (.*);

// >>> test/gplc_board_model.sv
// board side: pull-ups, external drivers, memory data pin
module gplc_board_model (
    input  wire logic [2:0] gpioOut,
    input  wire logic [2:0] gpioOe,
    input  wire logic [2:0] extOe,
    input  wire logic [2:0] extLevel,
    input  wire logic       dataPinOut,
    input  wire logic       dataPinOe,
    output logic      [2:0] gpioIn,
    output logic            cfgmemPinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        for (int i = 0; i < 3; i++)
            gpioIn[i] = gpioOe[i] ? gpioOut[i] : extOe[i] ? extLevel[i] : 1'b1;
        cfgmemPinIn = dataPinOe ? dataPinOut : 1'b1;
    end
endmodule

// >>> test/tb.sv
// self-checking bench for the pin configuration block
`include "gplc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CFG = `GPLC_CFG_OFFSET;
    localparam logic [11:0] STS = `GPLC_IRQ_STS_OFFSET;
    localparam logic [11:0] ENA = `GPLC_IRQ_EN_OFFSET;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        memOut, memOe, memClk, memIn, txEn, txClk, rxDv, rxClk, pinIn, dOut, dOe, cOut;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, d;
    logic [2:0]  gpioIn, gpioOut, gpioOe, ledState, extOe, extLevel, dir;
    logic        expD, expC;
    int          fail_count, tests_run, c, codes[$];
    gplc_pin_config u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .gpioIn, .gpioOut, .gpioOe, .ledState, .cfgmemDataOut(memOut),
        .cfgmemDataOe(memOe), .cfgmemClkOut(memClk), .cfgmemDataIn(memIn), .txEn, .txClk,
        .rxDv, .rxClk, .cfgmemPinIn(pinIn), .cfgmemDataPinOut(dOut), .cfgmemDataPinOe(dOe),
        .cfgmemClockPinOut(cOut), .irq);
    gplc_board_model u_board (.gpioOut, .gpioOe, .extOe, .extLevel, .dataPinOut(dOut),
        .dataPinOe(dOe), .gpioIn, .cfgmemPinIn(pinIn));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) fail_count++;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ledState, extOe, extLevel} = '0;
        {memOut, memOe, memClk, txEn, txClk, rxDv, rxClk} = '0;
        fail_count = 0;
        tests_run = 0;
        seed = 32'h545af107;
        codes = '{0, 1, 3, 5, 6, 7};
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, CFG, 32'h0);
        chk("cfg reset", 32'h7, rd);
        apb(1'b1, 12'h08c, 32'h1);
        chk("unmapped err", 32'h1, {31'h0, err});
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            d = ~`GPLC_CFG_WMASK | seed & 32'h0707071f | 32'h00100100 | (i & 1) << 16;
            dir = d[10:8];
            apb(1'b1, CFG, d);
            repeat (4) @(posedge ref_clk);
            chk("pin oe", {29'h0, dir & (d[18:16] | ~d[2:0])}, {29'h0, gpioOe});
            chk("gpo pins", {30'h0, d[4:3]}, {30'h0, cOut, dOut});
            apb(1'b0, CFG, 32'h0);
            chk("cfg read", d & `GPLC_CFG_WMASK & ~7 | {29'h0, dir & d[2:0] | ~dir}, rd);
        end
        ledState <= seed[10:8];
        apb(1'b1, CFG, 32'h70070700);
        repeat (3) @(posedge ref_clk);
        chk("led out", {29'h0, ledState}, {29'h0, gpioOut});
        foreach (codes[i]) begin
            c = codes[i];
            seed = lfsr(seed);
            apb(1'b1, CFG, {9'h0, c[2:0], 15'h0, seed[7:6], 3'h0});
            {memOut, memClk, txEn, txClk, rxDv, rxClk} <= seed[5:0];
            memOe <= 1'b1;
            repeat (3) @(posedge ref_clk);
            expD = c == 0 ? memOut : c < 4 ? seed[6] : c < 7 ? txEn : txClk;
            expC = c == 0 ? memClk : c == 1 || c == 5 ? seed[7] : c < 7 ? rxDv : rxClk;
            chk("mem pins", {30'h0, expD, expC}, {30'h0, dOut, cOut});
            chk("mem oe in", {30'h0, 1'b1, expD}, {30'h0, dOe, memIn});
            {memOe, memClk} <= 2'h0;
        end
        apb(1'b1, CFG, 32'h0);
        apb(1'b1, ENA, 32'h0);
        apb(1'b0, STS, 32'h0);
        extOe <= 3'h1;
        repeat (6) @(posedge ref_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, STS, 32'h0);
        chk("low level sts", 32'h1, rd);
        apb(1'b1, ENA, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, CFG, 32'h01000000);
        apb(1'b0, STS, 32'h0);
        repeat (5) @(posedge ref_clk);
        apb(1'b0, STS, 32'h0);
        chk("sts cleared", 32'h0, rd);
        chk("irq off", 32'h0, {31'h0, irq});
        extLevel <= 3'h1;
        repeat (6) @(posedge ref_clk);
        apb(1'b0, STS, 32'h0);
        chk("high level sts", 32'h1, rd);
        extOe <= 3'h3;
        @(posedge ref_clk);
        extOe <= 3'h1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, STS, 32'h0);
        chk("short pulse sts", 32'h3, rd);
        end_of_test();
    end
endmodule
